/* File: rtl/acd_pkg.sv */
// constants and types for the serial command byte decoder
// assumes a single sixteen-input converter core behind it
package acd_pkg;
    localparam int          ACD_NUM_IN    = 16;
    localparam int          ACD_NUM_PAIR  = 8;
    localparam logic [7:0]  ACD_ZERO_RST  = 8'h00;
    localparam logic [7:0]  ACD_SETUP_RST = 8'h20;
    localparam logic [2:0]  ACD_BYTE_LAST = 3'h7;
    // conversion byte fields
    localparam int          ACD_CONV_BIT  = 7;
    localparam int          ACD_CH_HI     = 6;
    localparam int          ACD_CH_LO     = 3;
    localparam int          ACD_SWP_HI    = 2;
    localparam int          ACD_SWP_LO    = 1;
    localparam int          ACD_TEMP_BIT  = 0;
    // setup byte fields
    localparam int          ACD_CK_HI     = 5;
    localparam int          ACD_CK_LO     = 4;
    localparam int          ACD_REF_HI    = 3;
    localparam int          ACD_REF_LO    = 2;
    localparam int          ACD_DIF_HI    = 1;
    localparam int          ACD_DIF_LO    = 0;
    // averaging and reset byte fields
    localparam int          ACD_AVG_EN    = 4;
    localparam int          ACD_NAVG_HI   = 3;
    localparam int          ACD_NAVG_LO   = 2;
    localparam int          ACD_NSCN_HI   = 1;
    localparam int          ACD_NSCN_LO   = 0;
    localparam int          ACD_RST_FLAG  = 3;
    // leading tag patterns
    localparam logic [1:0]  ACD_SETUP_TAG = 2'h1;
    localparam logic [2:0]  ACD_AVG_TAG   = 3'h1;
    localparam logic [3:0]  ACD_RST_TAG   = 4'h1;
    // mode codes
    localparam logic [1:0]  ACD_SWP_UP    = 2'h0;
    localparam logic [1:0]  ACD_SWP_DN    = 2'h1;
    localparam logic [1:0]  ACD_SWP_RPT   = 2'h2;
    localparam logic [1:0]  ACD_SWP_ONE   = 2'h3;
    localparam logic [1:0]  ACD_CK_EXT    = 2'h3;
    localparam logic [1:0]  ACD_REF_DIFF  = 2'h3;
    localparam logic [1:0]  ACD_DIF_UNI   = 2'h2;
    localparam logic [1:0]  ACD_DIF_BI    = 2'h3;
    // inputs that share a pin with start or negative reference
    localparam int          ACD_CONVERSION_START_PIN_IN  = 15;
    localparam int          ACD_REFN_IN   = 14;

    typedef enum logic [1:0] {
        ACD_ST_CMD = 2'b00,
        ACD_ST_UNI = 2'b01,
        ACD_ST_BI  = 2'b10
    } acd_state_e;
endpackage

/* File: rtl/acd_cfg_if.sv */
// configuration carrier between decoder and scan planner
// assumes both ends on the reference clock
`timescale 1ns/1ps
`default_nettype none
interface acd_cfg_if;
    logic [7:0]  conv;
    logic [7:0]  setup;
    logic [7:0]  uni;
    logic [7:0]  bi;
    logic [15:0] mask;
    logic [4:0]  count;
    modport ctl  (output conv, setup, uni, bi, input mask, count);
    modport plan (input conv, setup, uni, bi, output mask, count);
endinterface
`default_nettype wire

/* File: rtl/acd_link_rx.sv */
// serial link front end on the link clock
// assumes chip select frames every byte group and the link clock may stop
`timescale 1ns/1ps
`default_nettype none
module acd_link_rx
    import acd_pkg::*;
(
    input  wire logic       i_sclk,
    input  wire logic       i_cs_n,
    input  wire logic       i_reset,
    input  wire logic       i_sdi,
    output var  logic       o_sdo,
    output var  logic [7:0] o_byte,
    output var  logic       o_byte_tog
);
    logic       frame_rst;
    logic [2:0] cnt_r;
    logic [6:0] sh_r;

    // chip select high holds alignment at bit zero
    assign frame_rst = i_reset | i_cs_n;

    always_ff @(posedge i_sclk or posedge frame_rst) begin
        if (frame_rst) begin
            cnt_r <= 3'h0;
            sh_r  <= 7'h00;
        end else begin
            cnt_r <= cnt_r + 3'h1;
            sh_r  <= {sh_r[5:0], i_sdi};
        end
    end

    // toggle survives the frame so the event still crosses after select rises
    always_ff @(posedge i_sclk or posedge i_reset) begin
        if (i_reset) begin
            o_byte     <= ACD_ZERO_RST;
            o_byte_tog <= 1'b0;
        end else if (!i_cs_n && cnt_r == ACD_BYTE_LAST) begin
            o_byte     <= {sh_r, i_sdi};
            o_byte_tog <= ~o_byte_tog;
        end
    end

    // result readout lives elsewhere; line idles low as an empty fifo would
    always_ff @(negedge i_sclk or posedge i_reset) begin
        if (i_reset) begin
            o_sdo <= 1'b0;
        end else begin
            o_sdo <= 1'b0;
        end
    end
endmodule // acd_link_rx
`default_nettype wire

/* File: rtl/acd_scan_plan.sv */
// derives which inputs a scan converts and how many results it yields
// assumes the sixteen-input variant; combinational only
`timescale 1ns/1ps
`default_nettype none
module acd_scan_plan
    import acd_pkg::*;
(
    acd_cfg_if.plan cfg
);
    logic [3:0]  sel;
    logic [1:0]  swp;
    logic [15:0] excl;

    assign sel = cfg.conv[ACD_CH_HI:ACD_CH_LO];
    assign swp = cfg.conv[ACD_SWP_HI:ACD_SWP_LO];

    always_comb begin
        excl = 16'h0000;
        // start pin owns the top input outside the register-started modes
        excl[ACD_CONVERSION_START_PIN_IN] = !cfg.setup[ACD_CK_HI];
        excl[ACD_REFN_IN]  = cfg.setup[ACD_REF_HI:ACD_REF_LO] == ACD_REF_DIFF;
    end

    for (genvar g = 0; g < ACD_NUM_IN; g++) begin : g_in
        localparam int PB = ACD_NUM_PAIR - 1 - g / 2;
        localparam logic [3:0] IDX = 4'(g);
        logic diff;
        logic rng;
        assign diff = cfg.uni[PB] | cfg.bi[PB];
        // one local bit per input so no two processes share a variable
        always_comb begin
            unique case (swp)
                ACD_SWP_UP:  rng = IDX <= sel;
                ACD_SWP_DN:  rng = IDX >= sel;
                ACD_SWP_RPT: rng = IDX == sel;
                ACD_SWP_ONE: rng = IDX == sel;
            endcase
        end
        // a pair counts once on its lower input and dies if either member is lost
        assign cfg.mask[g] = rng & !excl[g]
                           & (!diff | ((g % 2 == 0) & !excl[g | 1]));
    end

    always_comb begin
        cfg.count = 5'(cfg.conv[ACD_TEMP_BIT]);
        for (int i = 0; i < ACD_NUM_IN; i++) begin
            cfg.count = cfg.count + 5'(cfg.mask[i]);
        end
    end
endmodule // acd_scan_plan
`default_nettype wire

/* File: rtl/acd_cmd_decoder.sv */
// top of the serial command byte decoder: control registers and scan request
// assumes a host acting as bus master on sclk/cs_n/sdi and a core taking the outputs
//
// Notes on behaviour
// - msb one means conversion byte: channel, sweep mode, temperature bit
// - four channel bits pick input zero to fifteen as plain binary
// - sweep 00 converts inputs zero up to the selected one
// - sweep 01 converts selected input up to the top input
// - sweep 10 repeats selected input; count from averaging repeat bits
// - sweep 11 converts the selected input once
// - sweeps 00/01 give one result per single input or pair, plus temperature
// - temperature bit adds one measurement as first result of the scan
// - timing modes 1x start on conversion byte; modes 0x on start pin low
// - inputs lent to start pin or negative reference are skipped, pairs too
// - setup bits 5:4 timing, 3:2 reference, 1:0 pair register target
// - target 10 loads next byte as unipolar, 11 as bipolar
// - target 00/01 leaves pair registers alone; next byte is a command
// - pair marked both ways counts as unipolar
// - unipolar pairs straight binary, bipolar pairs two's complement
// - averaging up to 32 samples, repeat count set separately
// - averaging only while averaging enable bit 4 is one
// - timing mode 11 never averages
// - reset byte flag one clears fifo only; zero restores all defaults
// - power-up registers zero except setup, which starts in timing mode 10
// - data sampled on rising link clock, output changes on falling edge
`timescale 1ns/1ps
`default_nettype none
module acd_cmd_decoder
    import acd_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_reset,
    input  wire logic        i_sclk,
    input  wire logic        i_cs_n,
    input  wire logic        i_sdi,
    input  wire logic        i_conversion_start_pin_n,
    output var  logic        o_sdo,
    output var  logic        o_scan_start,
    output var  logic        o_fifo_clear,
    output var  logic [3:0]  o_channel,
    output var  logic [1:0]  o_sweep_mode,
    output var  logic        o_temp_req,
    output var  logic [1:0]  o_timing_mode,
    output var  logic [1:0]  o_vref_choice,
    output var  logic [15:0] o_convert_mask,
    output var  logic [4:0]  o_result_count,
    output var  logic [7:0]  o_pair_bipolar,
    output var  logic        o_avg_active,
    output var  logic [1:0]  o_sample_count,
    output var  logic [1:0]  o_repeat_code
);

    ////////////////////////////////////////////////////////////////////////////
    // link side

    logic [7:0] rx_byte;
    logic       rx_tog;

    acd_link_rx u_rx (
        .i_sclk     (i_sclk),
        .i_cs_n     (i_cs_n),
        .i_reset    (i_reset),
        .i_sdi      (i_sdi),
        .o_sdo      (o_sdo),
        .o_byte     (rx_byte),
        .o_byte_tog (rx_tog)
    );

    ////////////////////////////////////////////////////////////////////////////
    // crossings into the reference clock

    logic tog_s1_r;
    logic tog_s2_r;
    logic tog_s3_r;
    logic cs_s1_r;
    logic cs_s2_r;
    logic cv_s1_r;
    logic cv_s2_r;
    logic cv_s3_r;
    logic byte_evt;
    logic cv_fall;

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            tog_s1_r <= 1'b0;
            tog_s2_r <= 1'b0;
            tog_s3_r <= 1'b0;
        end else begin
            tog_s1_r <= rx_tog;
            tog_s2_r <= tog_s1_r;
            tog_s3_r <= tog_s2_r;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
        end else begin
            cs_s1_r <= i_cs_n;
            cs_s2_r <= cs_s1_r;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            cv_s1_r <= 1'b1;
            cv_s2_r <= 1'b1;
            cv_s3_r <= 1'b1;
        end else begin
            cv_s1_r <= i_conversion_start_pin_n;
            cv_s2_r <= cv_s1_r;
            cv_s3_r <= cv_s2_r;
        end
    end

    // byte data is read only after its toggle crossed; the next byte is 8 link clocks away
    assign byte_evt = tog_s2_r ^ tog_s3_r;
    assign cv_fall  = cv_s3_r & !cv_s2_r;

    ////////////////////////////////////////////////////////////////////////////
    // byte decode

    logic is_conv;
    logic is_setup;
    logic is_avg;
    logic is_rst;
    logic [1:0] dif_sel;

    assign is_conv  = rx_byte[ACD_CONV_BIT];
    assign is_setup = rx_byte[7:6] == ACD_SETUP_TAG;
    assign is_avg   = rx_byte[7:5] == ACD_AVG_TAG;
    assign is_rst   = rx_byte[7:4] == ACD_RST_TAG;
    assign dif_sel  = rx_byte[ACD_DIF_HI:ACD_DIF_LO];

    acd_state_e st_r;
    acd_state_e st_nxt;
    logic       full_rst;

    assign full_rst = byte_evt && st_r == ACD_ST_CMD && is_rst && !rx_byte[ACD_RST_FLAG];

    always_comb begin
        st_nxt = st_r;
        if (byte_evt) begin
            unique case (st_r)
                ACD_ST_UNI: st_nxt = ACD_ST_CMD;
                ACD_ST_BI:  st_nxt = ACD_ST_CMD;
                ACD_ST_CMD: begin
                    if (!is_conv && is_setup && dif_sel == ACD_DIF_UNI) begin
                        st_nxt = ACD_ST_UNI;
                    end else if (!is_conv && is_setup && dif_sel == ACD_DIF_BI) begin
                        st_nxt = ACD_ST_BI;
                    end else begin
                        st_nxt = ACD_ST_CMD;
                    end
                end
                default: st_nxt = ACD_ST_CMD;
            endcase
        end else if (cs_s2_r) begin
            // a data byte must arrive within the same frame
            st_nxt = ACD_ST_CMD;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            st_r <= ACD_ST_CMD;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control registers

    logic [7:0] conv_r;
    logic [7:0] setup_r;
    logic [7:0] avg_r;
    logic [7:0] uni_r;
    logic [7:0] bi_r;
    logic       cmd_evt;

    assign cmd_evt = byte_evt && st_r == ACD_ST_CMD;

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            conv_r  <= ACD_ZERO_RST;
            setup_r <= ACD_SETUP_RST;
            avg_r   <= ACD_ZERO_RST;
        end else if (full_rst) begin
            conv_r  <= ACD_ZERO_RST;
            setup_r <= ACD_SETUP_RST;
            avg_r   <= ACD_ZERO_RST;
        end else if (cmd_evt) begin
            if (is_conv) begin
                conv_r <= rx_byte;
            end else if (is_setup) begin
                setup_r <= rx_byte;
            end else if (is_avg) begin
                avg_r <= rx_byte;
            end
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            uni_r <= ACD_ZERO_RST;
            bi_r  <= ACD_ZERO_RST;
        end else if (full_rst) begin
            uni_r <= ACD_ZERO_RST;
            bi_r  <= ACD_ZERO_RST;
        end else if (byte_evt && st_r == ACD_ST_UNI) begin
            uni_r <= rx_byte;
        end else if (byte_evt && st_r == ACD_ST_BI) begin
            bi_r <= rx_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // scan planning

    acd_cfg_if cfg ();

    assign cfg.conv  = conv_r;
    assign cfg.setup = setup_r;
    assign cfg.uni   = uni_r;
    assign cfg.bi    = bi_r;

    acd_scan_plan u_plan (
        .cfg (cfg)
    );

    ////////////////////////////////////////////////////////////////////////////
    // pulses toward the core

    logic start_nxt;
    logic fifo_nxt;

    // start pin is only a start source in the pin-started timing modes
    assign start_nxt = (cmd_evt && is_conv && setup_r[ACD_CK_HI])
                     || (cv_fall && !setup_r[ACD_CK_HI]);
    assign fifo_nxt  = cmd_evt && is_rst && rx_byte[ACD_RST_FLAG];

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_scan_start <= 1'b0;
            o_fifo_clear <= 1'b0;
        end else begin
            o_scan_start <= start_nxt;
            o_fifo_clear <= fifo_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered views of the configuration

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_channel      <= 4'h0;
            o_sweep_mode   <= 2'h0;
            o_temp_req     <= 1'b0;
            o_timing_mode  <= ACD_SETUP_RST[ACD_CK_HI:ACD_CK_LO];
            o_vref_choice  <= 2'h0;
            o_convert_mask <= 16'h0000;
            o_result_count <= 5'h00;
            o_pair_bipolar <= 8'h00;
            o_avg_active   <= 1'b0;
            o_sample_count <= 2'h0;
            o_repeat_code  <= 2'h0;
        end else begin
            o_channel      <= conv_r[ACD_CH_HI:ACD_CH_LO];
            o_sweep_mode   <= conv_r[ACD_SWP_HI:ACD_SWP_LO];
            o_temp_req     <= conv_r[ACD_TEMP_BIT];
            o_timing_mode  <= setup_r[ACD_CK_HI:ACD_CK_LO];
            o_vref_choice  <= setup_r[ACD_REF_HI:ACD_REF_LO];
            o_convert_mask <= cfg.mask;
            o_result_count <= cfg.count;
            // unipolar wins where both marks are set
            o_pair_bipolar <= bi_r & ~uni_r;
            o_avg_active   <= avg_r[ACD_AVG_EN]
                            && setup_r[ACD_CK_HI:ACD_CK_LO] != ACD_CK_EXT;
            o_sample_count <= avg_r[ACD_NAVG_HI:ACD_NAVG_LO];
            o_repeat_code  <= avg_r[ACD_NSCN_HI:ACD_NSCN_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);

    sequence s_setup_uni;
        cmd_evt && !is_conv && is_setup && dif_sel == ACD_DIF_UNI;
    endsequence

    sequence s_setup_plain;
        cmd_evt && !is_conv && is_setup && !dif_sel[ACD_DIF_HI];
    endsequence

    sequence s_data_byte;
        byte_evt && st_r == ACD_ST_UNI;
    endsequence

    conv_write_a: assert property (
        cmd_evt && is_conv |=> conv_r == $past(rx_byte))
        else $error("conversion byte not stored");

    setup_uni_a: assert property (
        s_setup_uni |=> st_r == ACD_ST_UNI)
        else $error("unipolar target not armed");

    uni_load_a: assert property (
        s_data_byte |=> uni_r == $past(rx_byte) && st_r == ACD_ST_CMD)
        else $error("data byte not loaded as unipolar");

    setup_plain_a: assert property (
        s_setup_plain |=> st_r == ACD_ST_CMD && $stable(uni_r) && $stable(bi_r))
        else $error("pair registers touched by plain setup");

    start_reg_a: assert property (
        cmd_evt && is_conv && setup_r[ACD_CK_HI] |=> o_scan_start)
        else $error("conversion byte did not start scan");

    start_pin_a: assert property (
        o_scan_start |-> $past(setup_r[ACD_CK_HI]) ? $past(cmd_evt && is_conv) : $past(cv_fall))
        else $error("scan start from wrong source");

    fifo_only_a: assert property (
        fifo_nxt |=> o_fifo_clear && $stable(setup_r) && $stable(conv_r))
        else $error("fifo reset disturbed registers");

    full_reset_a: assert property (
        full_rst |=> setup_r == ACD_SETUP_RST && conv_r == ACD_ZERO_RST && !o_fifo_clear)
        else $error("full reset missed defaults");

    avg_block_a: assert property (
        o_timing_mode == ACD_CK_EXT |-> !o_avg_active)
        else $error("averaging active in external timing");

    // unipolar mark never reads as bipolar; a bipolar-only mark always does
    polarity_a: assert property (
        ##1 (o_pair_bipolar & $past(uni_r)) == 8'h00
            && (o_pair_bipolar | $past(uni_r)) == ($past(bi_r) | $past(uni_r)))
        else $error("pair polarity wrong");

    single_count_a: assert property (
        conv_r[ACD_SWP_HI:ACD_SWP_LO] == ACD_SWP_ONE && $stable(conv_r) && $stable(setup_r)
        |=> o_result_count <= 5'(2))
        else $error("single conversion yields too many results");

endmodule // acd_cmd_decoder
`default_nettype wire

/* File: verification/acd_host_model.sv */
// host model: master on the serial command link
// assumes the decoder samples on the rising link clock
`timescale 1ns/1ps
`default_nettype none
module acd_host_model (
    output var logic o_sclk,
    output var logic o_cs_n,
    output var logic o_sdi
);
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_sdi  = 1'b1;
    end
    // one frame msb first; setup plus pair data spans 16 clocks
    // odd lead-in keeps link edges off the reference edges
    task automatic send(input logic [15:0] data, input int nbits);
        #3 o_cs_n = 1'b0;
        for (int i = nbits - 1; i >= 0; i--) begin
            o_sdi = data[i]; // data moves while link clock is low
            #24 o_sclk = 1'b1;
            #24 o_sclk = 1'b0;
        end
        #24 o_cs_n = 1'b1;
        o_sdi = ~o_sdi; // released line shows no stale level
        #48;
    endtask
endmodule // acd_host_model
`default_nettype wire

/* File: verification/adc_command_byte_decoder_tb.sv */
// self-checking bench for the command byte decoder
// assumes acd_host_model on the link; start pin driven here
`timescale 1ns/1ps
`default_nettype none
module adc_command_byte_decoder_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        conversion_start_pin_n = 1'b1;
    wire logic   sclk, cs_n, sdi;
    logic        sdo, start, clr, temp, avg;
    logic [3:0]  ch;
    logic [1:0]  swp, tm, vref, smp, rpt;
    logic [15:0] mask;
    logic [4:0]  cnt;
    logic [7:0]  bip;
    int          num_errors = 0;
    int          checks_done = 0;
    int          starts = 0;
    int          clears = 0;
    int          s;

    always #4 clk = ~clk;
    // pulses stand from one rising edge to the next; count them mid-cycle
    always @(negedge clk) begin
        if (start === 1'b1) starts++;
        if (clr === 1'b1) clears++;
    end

    acd_host_model acd_host_model_i (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi));
    acd_cmd_decoder acd_cmd_decoder_i (
        .i_ref_clk(clk), .i_reset(rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_sdi(sdi),
        .i_conversion_start_pin_n(conversion_start_pin_n), .o_sdo(sdo), .o_scan_start(start), .o_fifo_clear(clr),
        .o_channel(ch), .o_sweep_mode(swp), .o_temp_req(temp), .o_timing_mode(tm),
        .o_vref_choice(vref), .o_convert_mask(mask), .o_result_count(cnt),
        .o_pair_bipolar(bip), .o_avg_active(avg), .o_sample_count(smp), .o_repeat_code(rpt));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // effect lands within a few reference clocks of the last link edge
    task automatic tx(input logic [15:0] d, input int n);
        @(negedge clk);
        acd_host_model_i.send(d, n);
        repeat (8) @(negedge clk);
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic t_reset;
        chk(tm, 2'b10);
        chk({ch, swp, temp, vref, smp, rpt, avg, sdo}, 0);
        // zero conversion register still names input zero in sweep 00
        chk({mask, cnt, bip}, {16'h0001, 5'h01, 8'h00});
    endtask
    task automatic t_conv;
        s = starts;
        tx(16'h0087, 8);
        chk(starts - s, 1);
        chk(swp, 2'h3);
        chk(temp, 1'b1);
        chk(mask, 16'h0001);
        chk(cnt, 5'h02);
    endtask
    task automatic t_scan;
        tx(16'h00A8, 8);
        chk(ch, 4'h5);
        chk(mask, 16'h003F);
        chk(cnt, 5'h06);
        tx(16'h00E2, 8);
        chk(mask, 16'hF000);
        chk(cnt, 5'h04);
        tx(16'h00F4, 8);
        chk(mask, 16'h4000);
        chk(cnt, 5'h01);
    endtask
    task automatic t_pairs;
        tx(16'h63C0, 16);
        chk(bip, 8'hC0);
        tx(16'h6280, 16);
        chk(bip, 8'h40);
        tx(16'h0068, 8);
        chk(vref, 2'h2);
        chk(bip, 8'h40);
        s = starts;
        tx(16'h6187, 16);
        chk(starts - s, 1);
        tx(16'h0096, 8); // lower input of pair 2/3
        chk({mask, cnt}, {16'h0004, 5'h01});
        tx(16'h0098, 8); // pairs 0/1 and 2/3 in range
        chk({mask, cnt}, {16'h0005, 5'h02});
    endtask
    task automatic t_avg;
        tx(16'h003D, 8);
        chk({avg, smp, rpt}, 5'h1D);
        tx(16'h0070, 8);
        chk(avg, 1'b0);
        s = starts;
        tx(16'h0087, 8);
        chk(starts - s, 1);
        tx(16'h0060, 8);
        chk(avg, 1'b1);
        tx(16'h002F, 8);
        chk({avg, smp, rpt}, 5'h0F);
    endtask
    task automatic t_rst_byte;
        s = clears;
        tx(16'h0005, 8);
        tx(16'h0018, 8);
        chk(clears - s, 1);
        chk({smp, rpt}, 4'hF);
        tx(16'h0010, 8);
        chk({tm, vref, bip, smp, rpt}, 16'h8000);
    endtask
    task automatic t_pin;
        tx(16'h0040, 8);
        s = starts;
        tx(16'h00F2, 8); // ch14 is a real input on this variant
        chk(starts - s, 0);
        chk(mask, 16'h4000);
        @(negedge clk) conversion_start_pin_n = 1'b0;
        repeat (4) @(negedge clk);
        conversion_start_pin_n = 1'b1;
        repeat (8) @(negedge clk);
        chk(starts - s, 1);
        tx(16'h004C, 8);
        chk({mask, cnt}, 0);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        repeat (4) @(negedge clk);
        t_reset();
        t_conv();
        t_scan();
        t_pairs();
        t_avg();
        t_rst_byte();
        t_pin();
        final_report();
    end
    initial begin
        #400_000;
        num_errors++;
        final_report();
    end
endmodule // adc_command_byte_decoder_tb
`default_nettype wire
